// ### verilog/acalu_pkg.sv
// package for the accumulator alu datapath
package acalu_pkg;

  localparam int NIB_W  = 4;
  localparam int ROM_W  = 8;
  localparam int ADDR_W = 11;
  localparam int PAGE_W = 4;

  localparam logic [3:0] ACC_RST   = 4'h0;
  localparam logic [3:0] REGB_RST  = 4'h0;
  localparam logic       CARRY_RST = 1'b0;
  localparam logic [3:0] ZERO_NIB  = 4'h0;

  localparam int ROM_HI_MSB = 7;
  localparam int ROM_HI_LSB = 4;
  localparam int ROM_LO_MSB = 3;
  localparam int ROM_LO_LSB = 0;

  typedef enum logic [3:0] {
    ACALU_NOP     = 4'h0,
    ACALU_LDI     = 4'h1,
    ACALU_TAB     = 4'h2,
    ACALU_ADDM    = 4'h3,
    ACALU_ADDMC   = 4'h4,
    ACALU_ADDI    = 4'h5,
    ACALU_SETC    = 4'h6,
    ACALU_CLRC    = 4'h7,
    ACALU_TSTC    = 4'h8,
    ACALU_CPL     = 4'h9,
    ACALU_ROR     = 4'ha,
    ACALU_LOGIC   = 4'hb
  } acalu_op_t;

  typedef enum logic [1:0] {
    ACALU_FN_XOR = 2'b00,
    ACALU_FN_OR  = 2'b01,
    ACALU_FN_AND = 2'b10
  } acalu_fn_t;

  typedef enum logic [1:0] {
    ACALU_IDLE  = 2'b00,
    ACALU_TADDR = 2'b01,
    ACALU_TWAIT = 2'b10
  } acalu_state_t;

  typedef struct packed {
    logic            valid;
    acalu_op_t       op;
    logic [3:0]      imm;
  } acalu_instr_t;

  typedef struct packed {
    logic            req;
    logic [PAGE_W-1:0] page;
    logic [2:0]      dreg;
    logic [3:0]      acc;
  } acalu_rom_req_t;

endpackage : acalu_pkg

// ### verilog/acalu_core.sv
// accumulator alu datapath core
`timescale 1ns/1ps
module acalu_core (
  // clock and reset
  input  wire logic                     core_clk,
  input  wire logic                     rst,
  // decoded instruction
  input  wire acalu_pkg::acalu_instr_t  instr,
  // operand sources
  input  wire logic [3:0]               pointed_memory_nibble,
  input  wire logic [3:0]               port_s,
  input  wire logic [2:0]               reg_d,
  input  wire acalu_pkg::acalu_fn_t     gate_function_select,
  input  wire logic                     stack_level_free,
  // table rom
  input  wire logic [7:0]               rom_data,
  input  wire logic                     rom_valid,
  output acalu_pkg::acalu_rom_req_t     rom_req,
  // state outputs
  output logic [3:0]                    acc,
  output logic [3:0]                    reg_b,
  output logic                          carry_flag,
  output logic                          skip_next,
  output logic                          stack_push,
  output logic                          stack_pop,
  output logic                          busy,
  output logic                          stack_fault
);
  import acalu_pkg::*;

  // registered state
  logic [3:0]     acc_q;
  logic [3:0]     acc_d;
  logic [3:0]     reg_b_q;
  logic [3:0]     reg_b_d;
  logic           carry_q;
  logic           carry_d;
  logic           skip_q;
  logic           skip_d;
  logic           prev_ldi_q;
  acalu_state_t   state_q;
  acalu_state_t   state_d;
  acalu_rom_req_t rom_req_q;
  logic           push_q;
  logic           pop_q;
  logic           busy_q;
  logic           fault_q;

  // decode helpers
  logic           taken;
  logic           ldi_follow;
  logic           exec;
  logic           tab_start;
  logic           tab_done;
  logic [4:0]     sum_m;
  logic [4:0]     sum_mc;
  logic [4:0]     sum_i;
  logic [3:0]     logic_res;

  // outputs straight from flip-flops
  assign acc         = acc_q;
  assign reg_b       = reg_b_q;
  assign carry_flag  = carry_q;
  assign skip_next   = skip_q;
  assign rom_req     = rom_req_q;
  assign stack_push  = push_q;
  assign stack_pop   = pop_q;
  assign busy        = busy_q;
  assign stack_fault = fault_q;

  // a valid instruction is taken whenever the sequencer is idle
  assign taken      = instr.valid && (state_q == ACALU_IDLE);
  assign ldi_follow = (instr.op == ACALU_LDI) && prev_ldi_q;
  assign exec       = taken && !skip_q && !ldi_follow;
  assign tab_start  = exec && (instr.op == ACALU_TAB);
  assign tab_done   = (state_q == ACALU_TWAIT) && rom_valid;

  // 5-bit sums keep the carry out
  assign sum_m  = {1'b0, acc_q} + {1'b0, pointed_memory_nibble};
  assign sum_mc = {1'b0, acc_q} + {1'b0, pointed_memory_nibble} + {4'h0, carry_q};
  assign sum_i  = {1'b0, acc_q} + {1'b0, instr.imm};

  always_comb begin
    case (gate_function_select)
      ACALU_FN_XOR: logic_res = acc_q ^ port_s;
      ACALU_FN_OR:  logic_res = acc_q | port_s;
      ACALU_FN_AND: logic_res = acc_q & port_s;
      default:      logic_res = acc_q;
    endcase
  end

  // accumulator next value
  always_comb begin
    acc_d = acc_q;
    if (tab_done) begin
      acc_d = rom_data[ROM_LO_MSB:ROM_LO_LSB];
    end else if (exec) begin
      case (instr.op)
        ACALU_LDI:   acc_d = instr.imm;
        ACALU_ADDM:  acc_d = sum_m[3:0];
        ACALU_ADDMC: acc_d = sum_mc[3:0];
        ACALU_ADDI:  acc_d = sum_i[3:0];
        ACALU_CPL:   acc_d = ~acc_q;
        ACALU_ROR:   acc_d = {carry_q, acc_q[3:1]};
        ACALU_LOGIC: acc_d = logic_res;
        default:     acc_d = acc_q;
      endcase
    end
  end

  // register b next value
  always_comb begin
    reg_b_d = reg_b_q;
    if (tab_done) begin
      reg_b_d = rom_data[ROM_HI_MSB:ROM_HI_LSB];
    end
  end

  // carry next value
  always_comb begin
    carry_d = carry_q;
    if (exec) begin
      case (instr.op)
        ACALU_ADDMC: carry_d = sum_mc[4];
        ACALU_SETC:  carry_d = 1'b1;
        ACALU_CLRC:  carry_d = 1'b0;
        ACALU_ROR:   carry_d = acc_q[0];
        default:     carry_d = carry_q;
      endcase
    end
  end

  // skip next value
  always_comb begin
    skip_d = skip_q;
    if (taken) begin
      // any taken slot clears a pending skip
      skip_d = 1'b0;
      if (exec) begin
        case (instr.op)
          ACALU_ADDI: skip_d = !sum_i[4];
          ACALU_TSTC: skip_d = !carry_q;
          default:    skip_d = 1'b0;
        endcase
      end
    end
  end

  // table fetch sequencer next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      ACALU_IDLE: begin
        if (tab_start) begin
          state_d = ACALU_TADDR;
        end
      end
      ACALU_TADDR: begin
        state_d = ACALU_TWAIT;
      end
      ACALU_TWAIT: begin
        if (rom_valid) begin
          state_d = ACALU_IDLE;
        end
      end
      default: state_d = ACALU_IDLE;
    endcase
  end

  // accumulator
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      acc_q <= ACC_RST;
    end else begin
      acc_q <= acc_d;
    end
  end

  // register b
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_b_q <= REGB_RST;
    end else begin
      reg_b_q <= reg_b_d;
    end
  end

  // carry flag
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      carry_q <= CARRY_RST;
    end else begin
      carry_q <= carry_d;
    end
  end

  // skip flag
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      skip_q <= 1'b0;
    end else begin
      skip_q <= skip_d;
    end
  end

  // sequencer state
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q <= ACALU_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // last taken slot was a load
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prev_ldi_q <= 1'b0;
    end else if (taken) begin
      prev_ldi_q <= (instr.op == ACALU_LDI);
    end
  end

  // table rom request
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rom_req_q <= '0;
    end else begin
      rom_req_q.req <= tab_start;
      if (tab_start) begin
        // page, then d bits, then accumulator bits
        rom_req_q.page <= instr.imm;
        rom_req_q.dreg <= reg_d;
        rom_req_q.acc  <= acc_q;
      end
    end
  end

  // stack level taken for the fetch
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      push_q <= 1'b0;
    end else begin
      push_q <= tab_start;
    end
  end

  // stack level released after the fetch
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pop_q <= 1'b0;
    end else begin
      pop_q <= tab_done;
    end
  end

  // busy while the fetch is in flight
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      busy_q <= 1'b0;
    end else if (tab_start) begin
      busy_q <= 1'b1;
    end else if (tab_done) begin
      busy_q <= 1'b0;
    end
  end

  // fault holds until the next table fetch
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      fault_q <= 1'b0;
    end else if (tab_start) begin
      fault_q <= !stack_level_free;
    end
  end

endmodule : acalu_core

// ### testbench/acalu_core_monitor.sv
// checker for the accumulator alu core
`timescale 1ns/1ps
module acalu_mon
  import acalu_pkg::*;
(
  // watched ports
  input wire logic           core_clk,
  input wire logic           rst,
  input wire acalu_instr_t   instr,
  input wire logic [2:0]     reg_d,
  input wire acalu_rom_req_t rom_req,
  input wire logic [3:0]     acc,
  input wire logic           carry_flag,
  input wire logic           skip_next,
  input wire logic           busy,
  input wire logic           stack_push,
  input wire logic           stack_pop,
  input wire logic [3:0]     reg_b,
  input wire logic [3:0]     pointed_memory_nibble,
  input wire logic [3:0]     port_s,
  input wire acalu_fn_t      gate_function_select,
  input wire logic [7:0]     rom_data,
  input wire logic           rom_valid
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  wire tk = instr.valid && !busy;
  wire [15:0] g = 16'(tk && !skip_next) << instr.op;
  logic ld_q;
  // last taken slot was a load
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ld_q <= 1'b0;
    end else if (tk) begin
      ld_q <= instr.op == ACALU_LDI;
    end
  end
  property p_ld;
    g[ACALU_LDI] && !ld_q |=> acc == $past(instr.imm);
  endproperty
  a_ld: assert property (p_ld) else $error("bad load");
  property p_run;
    tk && instr.op == ACALU_LDI && ld_q |=> $stable(acc) && $stable(carry_flag) && !skip_next;
  endproperty
  a_run: assert property (p_run) else $error("load run follower acted");
  property p_ai;
    g[ACALU_ADDI] |=> {!skip_next, acc} == $past({1'b0, acc} + instr.imm) && $stable(carry_flag);
  endproperty
  a_ai: assert property (p_ai) else $error("bad add imm");
  property p_sc; g[ACALU_SETC] |=> carry_flag && $stable(acc); endproperty
  a_sc: assert property (p_sc) else $error("bad set carry");
  property p_tc; g[ACALU_TSTC] |=> skip_next != $past(carry_flag); endproperty
  a_tc: assert property (p_tc) else $error("bad carry test");
  property p_cpl; g[ACALU_CPL] |=> acc == ~$past(acc) && $stable(carry_flag); endproperty
  a_cpl: assert property (p_cpl) else $error("bad complement");
  property p_ror; g[ACALU_ROR] |=> {acc, carry_flag} == $past({carry_flag, acc}); endproperty
  a_ror: assert property (p_ror) else $error("bad rotate");
  property p_tab;
    g[ACALU_TAB] |=> stack_push && busy && rom_req == $past({1'b1, instr.imm, reg_d, acc});
  endproperty
  a_tab: assert property (p_tab) else $error("bad table request");
  property p_skp; tk && skip_next |=> $stable(acc) && $stable(carry_flag); endproperty
  a_skp: assert property (p_skp) else $error("skipped op acted");
  property p_cc; g[ACALU_CLRC] |=> !carry_flag && $stable(acc); endproperty
  a_cc: assert property (p_cc) else $error("bad clear carry");
  property p_am;
    g[ACALU_ADDM] |=> acc == $past(4'(acc + pointed_memory_nibble)) && $stable(carry_flag);
  endproperty
  a_am: assert property (p_am) else $error("bad add memory");
  property p_amc;
    g[ACALU_ADDMC] |=>
      {carry_flag, acc} == $past({1'b0, acc} + pointed_memory_nibble + carry_flag);
  endproperty
  a_amc: assert property (p_amc) else $error("bad add with carry");
  property p_lg;
    g[ACALU_LOGIC] && gate_function_select inside {ACALU_FN_XOR, ACALU_FN_OR, ACALU_FN_AND}
      |=> acc == $past(gate_function_select == ACALU_FN_XOR ? acc ^ port_s :
                       gate_function_select == ACALU_FN_OR ? acc | port_s : acc & port_s);
  endproperty
  a_lg: assert property (p_lg) else $error("bad port combine");
  property p_tw;
    busy && $past(busy) && rom_valid |=> {reg_b, acc} == $past(rom_data) && stack_pop && !busy;
  endproperty
  a_tw: assert property (p_tw) else $error("bad table word");
  c_tab: cover property (rom_req.req);
  c_skp: cover property (tk && skip_next);
  c_ovf: cover property (g[ACALU_ADDI] && instr.imm + acc > 5'h0f);
endmodule : acalu_mon
bind acalu_core acalu_mon u_mon (
  .core_clk              (core_clk),
  .rst                   (rst),
  .instr                 (instr),
  .reg_d                 (reg_d),
  .rom_req               (rom_req),
  .acc                   (acc),
  .carry_flag            (carry_flag),
  .skip_next             (skip_next),
  .busy                  (busy),
  .stack_push            (stack_push),
  .stack_pop             (stack_pop),
  .reg_b                 (reg_b),
  .pointed_memory_nibble (pointed_memory_nibble),
  .port_s                (port_s),
  .gate_function_select  (gate_function_select),
  .rom_data              (rom_data),
  .rom_valid             (rom_valid)
);

// ### testbench/acalu_bench.sv
// random and directed bench for the accumulator alu core
`timescale 1ns/1ps
module acalu_bench;
  import acalu_pkg::*;
  logic core_clk = 0, rst = 1, rom_valid = 0, stack_level_free = 1;
  logic ecy = 0, esk = 0, eld = 0, sk, carry_flag, skip_next, busy;
  logic stack_push, stack_pop, stack_fault;
  logic [3:0] m = 0, port_s = 0, ea = 0, eb = 0, acc, reg_b;
  logic [2:0] reg_d = 0;
  logic [7:0] rom_data = 8'h15;
  acalu_instr_t instr = '0;
  acalu_fn_t f = ACALU_FN_XOR;
  acalu_rom_req_t rom_req;
  int fails = 0, cmp_count = 0;
  acalu_core i_dut (
    .core_clk              (core_clk),
    .rst                   (rst),
    .instr                 (instr),
    .pointed_memory_nibble (m),
    .port_s                (port_s),
    .reg_d                 (reg_d),
    .gate_function_select  (f),
    .stack_level_free      (stack_level_free),
    .rom_data              (rom_data),
    .rom_valid             (rom_valid),
    .rom_req               (rom_req),
    .acc                   (acc),
    .reg_b                 (reg_b),
    .carry_flag            (carry_flag),
    .skip_next             (skip_next),
    .stack_push            (stack_push),
    .stack_pop             (stack_pop),
    .busy                  (busy),
    .stack_fault           (stack_fault)
  );
  initial forever #5 core_clk = ~core_clk;
  initial #100000 begin
    fails++;
    final_report();
  end
  function automatic logic [7:0] nx(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : nx
  task automatic chk(input string n, input logic [11:0] e, g);
    cmp_count++;
    if (e !== g) begin
      fails++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic final_report();
    if (fails == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : final_report
  task automatic step(input acalu_op_t o, input logic [3:0] im);
    rom_data = nx(rom_data);
    {m, port_s} = rom_data;
    reg_d = rom_data[2:0];
    stack_level_free = rom_data[5];
    f = acalu_fn_t'(2'(rom_data % 8'h3));
    instr = '{1'b1, o, im};
    sk = esk || (eld && o == ACALU_LDI);
    eld = o == ACALU_LDI;
    esk = 0;
    @(posedge core_clk);
    #1;
    if (!sk) case (o)
      ACALU_LDI: ea = im;
      ACALU_ADDM: ea = ea + m;
      ACALU_ADDMC: {ecy, ea} = ea + m + ecy;
      ACALU_ADDI: {esk, ea} = ({1'b0, ea} + im) ^ 5'h10;
      ACALU_SETC: ecy = 1;
      ACALU_CLRC: ecy = 0;
      ACALU_TSTC: esk = !ecy;
      ACALU_CPL: ea = ~ea;
      ACALU_ROR: {ea, ecy} = {ecy, ea};
      ACALU_LOGIC: ea = f == ACALU_FN_XOR ? ea ^ port_s : f == ACALU_FN_OR ? ea | port_s : ea & port_s;
      ACALU_TAB: begin
        chk("rom_req", {1'b1, im, reg_d, ea}, rom_req);
        chk("push_busy_fault", {2'b11, !stack_level_free}, {stack_push, busy, stack_fault});
        repeat (2) @(posedge core_clk);
        #1 rom_valid = 1;
        @(posedge core_clk);
        #1 rom_valid = 0;
        chk("push_pop_busy", 3'b010, {stack_push, stack_pop, busy});
        {eb, ea} = rom_data;
      end
      default: ;
    endcase
    chk("skip_carry_b_acc", {esk, ecy, eb, ea}, {skip_next, carry_flag, reg_b, acc});
  endtask : step
  initial begin
    repeat (8) @(posedge core_clk);
    #1 rst = 0;
    step(ACALU_LDI, 4'h5);
    step(ACALU_LDI, 4'h9);
    step(ACALU_ADDI, 4'hb);
    step(ACALU_ADDI, 4'h0);
    step(ACALU_TAB, 4'h7);
    step(ACALU_TSTC, 4'h0);
    step(ACALU_CPL, 4'h0);
    repeat (600) step(acalu_op_t'(4'(rom_data % 8'hc)), rom_data[7:4]);
    final_report();
  end
endmodule : acalu_bench
